// ==== shared/lbac_pkg.sv ====
package lbac_pkg;
   localparam int            NUM_INIT      = 8;
   localparam int            ID_W          = 3;
   localparam logic [7:0]    OP_RD_LONG    = 8'h3E;
   localparam logic [7:0]    OP_WR_LONG    = 8'h3F;
   localparam logic [7:0]    OP_INQUIRY    = 8'h12;
   localparam logic [7:0]    OP_REQ_SENSE  = 8'h03;
   localparam logic [7:0]    OP_PRIO_RSV   = 8'hC0;
   localparam logic [15:0]   ECC_LEN       = 16'h0007;
   localparam logic [15:0]   SZ_SHORT      = 16'h0100;
   localparam logic [15:0]   SZ_SGL_MIN    = 16'h01EC;
   localparam logic [15:0]   SZ_SGL_MAX    = 16'h0214;
   localparam logic [15:0]   SZ_DBL_MIN    = 16'h03D8;
   localparam logic [15:0]   SZ_DBL_MAX    = 16'h0428;
   localparam logic [15:0]   BLK_RST       = 16'h0200;
   localparam logic [3:0]    SK_ILLEGAL    = 4'h5;
   localparam logic [3:0]    SK_UNIT_ATTN  = 4'h6;
   localparam logic [7:0]    ASC_BAD_FIELD = 8'h24;
   localparam logic [7:0]    ASC_UA        = 8'h29;
   localparam logic [7:0]    REG_UA        = 8'h00;
   localparam logic [7:0]    REG_BLK       = 8'h04;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_XFER = 1'b1
   } lbac_fsm_t;

   typedef enum logic [1:0] {
      RK_PASS  = 2'b00,
      RK_GOOD  = 2'b01,
      RK_CHECK = 2'b10,
      RK_XFER  = 2'b11
   } lbac_kind_t;

   typedef struct packed {
      logic [7:0]  op;
      logic [7:0]  b1;
      logic [31:0] lba;
      logic [7:0]  b6;
      logic [15:0] len;
      logic [7:0]  ctl;
   } lbac_cdb_t;

   typedef struct packed {
      lbac_kind_t  kind;
      logic [3:0]  skey;
      logic [7:0]  asc;
      logic        valid;
      logic        ili;
      logic [31:0] info;
      logic        ua_sense;
      logic        seek;
      logic        wr;
      logic [31:0] lba;
   } lbac_res_t;
endpackage : lbac_pkg

// ==== hw/lbac_top.sv ====
// The strobed register port and the register addresses were decided locally.
module lbac_top (
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output      logic [31:0]         reg_rdata,
   input  wire logic                cmd_vld,
   input  wire logic [2:0]          cmd_id,
   input  wire lbac_pkg::lbac_cdb_t cmd_cdb,
   output      logic                res_vld,
   output      lbac_pkg::lbac_res_t res,
   input  wire logic                ready_rise,
   input  wire logic                bus_rst,
   input  wire logic                mode_chg,
   input  wire logic [2:0]          mode_chg_id,
   input  wire logic [15:0]         mode_chg_size,
   input  wire logic                in_vld,
   input  wire logic [7:0]          in_byte,
   output      logic                in_rdy,
   output      logic                out_vld,
   output      logic [7:0]          out_byte,
   output      logic                out_ecc,
   output      logic                out_half,
   output      logic                out_last,
   input  wire logic                out_rdy,
   output      logic                xfer_done
);
   typedef struct packed {
      lbac_pkg::lbac_fsm_t st;
      logic [7:0]          ua;
      logic [15:0]         blk;
      logic [15:0]         len;
      logic [15:0]         hlen;
      logic [15:0]         idx;
      lbac_pkg::lbac_res_t res;
      logic                res_vld;
      logic [31:0]         rdata;
      logic                in_rdy;
      logic                out_vld;
      logic [7:0]          out_byte;
      logic                out_ecc;
      logic                out_half;
      logic                out_last;
      logic                done;
   } lbac_st_t;

   lbac_st_t s_ff;
   lbac_st_t nxt_s;

   // Expected image length and whether the block is split in two halves.
   function automatic logic [16:0] lbac_exp(input logic [15:0] b);
      if (b >= lbac_pkg::SZ_DBL_MIN && b <= lbac_pkg::SZ_DBL_MAX) begin
         lbac_exp = {1'b1, 16'(b + lbac_pkg::ECC_LEN + lbac_pkg::ECC_LEN)};
      end else begin
         lbac_exp = {1'b0, 16'(b + lbac_pkg::ECC_LEN)};
      end
   endfunction : lbac_exp

   // Position tag of an image byte: {second half, ECC byte}.
   function automatic logic [1:0] lbac_tag(input logic [15:0] i, input logic [15:0] h);
      if (i < h) begin
         lbac_tag = 2'b00;
      end else if (i < 16'(h + lbac_pkg::ECC_LEN)) begin
         lbac_tag = 2'b01;
      end else if (i < 16'(h + lbac_pkg::ECC_LEN + h)) begin
         lbac_tag = 2'b10;
      end else begin
         lbac_tag = 2'b11;
      end
   endfunction : lbac_tag

   logic        is_long;
   logic        exempt;
   logic        ua_hit;
   logic        rsv_bad;
   logic [16:0] exp_l;
   logic        len_ok;
   logic [16:0] diff;
   logic        take;

   assign take    = cmd_vld && s_ff.st == lbac_pkg::ST_IDLE;
   assign is_long = cmd_cdb.op == lbac_pkg::OP_RD_LONG || cmd_cdb.op == lbac_pkg::OP_WR_LONG;
   assign exempt  = cmd_cdb.op == lbac_pkg::OP_INQUIRY || cmd_cdb.op == lbac_pkg::OP_REQ_SENSE
                    || cmd_cdb.op == lbac_pkg::OP_PRIO_RSV;
   assign ua_hit  = s_ff.ua[cmd_id];
   assign rsv_bad = cmd_cdb.b1[4:0] != 5'h00 || cmd_cdb.b6 != 8'h00;
   assign exp_l   = lbac_exp(s_ff.blk);
   assign len_ok  = cmd_cdb.len == exp_l[15:0];
   assign diff    = {1'b0, cmd_cdb.len} - {1'b0, exp_l[15:0]};

   always_comb begin
      nxt_s         = s_ff;
      nxt_s.res_vld = 1'b0;
      nxt_s.done    = 1'b0;
      nxt_s.rdata   = 32'h0000_0000;
      if (reg_rd) begin
         if (reg_addr == lbac_pkg::REG_UA) begin
            nxt_s.rdata = {24'h00_0000, s_ff.ua};
         end else if (reg_addr == lbac_pkg::REG_BLK) begin
            nxt_s.rdata = {16'h0000, s_ff.blk};
         end
      end
      if (reg_wr && reg_addr == lbac_pkg::REG_BLK) begin
         nxt_s.blk = reg_wdata[15:0];
      end
      // Bytes go through untouched; only their position is tagged.
      if (s_ff.out_vld && out_rdy) begin
         nxt_s.out_vld = 1'b0;
         if (s_ff.out_last) begin
            nxt_s.st   = lbac_pkg::ST_IDLE;
            nxt_s.done = 1'b1;
         end else begin
            nxt_s.in_rdy = 1'b1;
         end
      end
      if (s_ff.in_rdy && in_vld) begin
         nxt_s.in_rdy   = 1'b0;
         nxt_s.out_vld  = 1'b1;
         nxt_s.out_byte = in_byte;
         {nxt_s.out_half, nxt_s.out_ecc} = lbac_tag(s_ff.idx, s_ff.hlen);
         nxt_s.out_last = s_ff.idx == 16'(s_ff.len - 16'h0001);
         nxt_s.idx      = 16'(s_ff.idx + 16'h0001);
      end
      // Commands arriving during a transfer are left to the bus layer, which answers busy.
      if (take) begin
         nxt_s.res_vld = 1'b1;
         nxt_s.res     = '0;
         nxt_s.res.lba = cmd_cdb.lba;
         nxt_s.res.wr  = cmd_cdb.op == lbac_pkg::OP_WR_LONG;
         if (ua_hit && !exempt) begin
            nxt_s.res.kind    = lbac_pkg::RK_CHECK;
            nxt_s.res.skey    = lbac_pkg::SK_UNIT_ATTN;
            nxt_s.res.asc     = lbac_pkg::ASC_UA;
            nxt_s.ua[cmd_id]  = 1'b0;
         end else begin
            nxt_s.res.kind = lbac_pkg::RK_PASS;
            if (cmd_cdb.op == lbac_pkg::OP_REQ_SENSE && ua_hit) begin
               nxt_s.res.ua_sense = 1'b1;
               nxt_s.res.skey     = lbac_pkg::SK_UNIT_ATTN;
               nxt_s.res.asc      = lbac_pkg::ASC_UA;
               nxt_s.ua[cmd_id]   = 1'b0;
            end
            if (cmd_cdb.op == lbac_pkg::OP_PRIO_RSV) begin
               nxt_s.ua[cmd_id] = 1'b0;
            end
            if (is_long) begin
               if (rsv_bad) begin
                  nxt_s.res.kind = lbac_pkg::RK_CHECK;
                  nxt_s.res.skey = lbac_pkg::SK_ILLEGAL;
                  nxt_s.res.asc  = lbac_pkg::ASC_BAD_FIELD;
               end else if (cmd_cdb.len == 16'h0000) begin
                  nxt_s.res.kind = lbac_pkg::RK_GOOD;
                  nxt_s.res.seek = 1'b1;
               end else if (!len_ok) begin
                  nxt_s.res.kind  = lbac_pkg::RK_CHECK;
                  nxt_s.res.skey  = lbac_pkg::SK_ILLEGAL;
                  nxt_s.res.asc   = lbac_pkg::ASC_BAD_FIELD;
                  nxt_s.res.valid = 1'b1;
                  nxt_s.res.ili   = 1'b1;
                  nxt_s.res.info  = {{15{diff[16]}}, diff};
               end else begin
                  nxt_s.res.kind = lbac_pkg::RK_XFER;
                  nxt_s.res.seek = 1'b1;
                  nxt_s.st       = lbac_pkg::ST_XFER;
                  nxt_s.len      = cmd_cdb.len;
                  nxt_s.hlen     = exp_l[16] ? {1'b0, s_ff.blk[15:1]} : s_ff.blk;
                  nxt_s.idx      = 16'h0000;
                  nxt_s.in_rdy   = 1'b1;
               end
            end
         end
      end
      // Set events come last so a flag set in the cycle of its clear stays set.
      if (mode_chg) begin
         nxt_s.blk = mode_chg_size;
         nxt_s.ua  = nxt_s.ua | ~(8'h01 << mode_chg_id);
      end
      if (ready_rise || bus_rst) begin
         nxt_s.ua = 8'hFF;
      end
      if (bus_rst) begin
         nxt_s.st      = lbac_pkg::ST_IDLE;
         nxt_s.in_rdy  = 1'b0;
         nxt_s.out_vld = 1'b0;
         nxt_s.res_vld = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         // Power-up counts as a reset, so every host starts with attention pending.
         s_ff <= '{st: lbac_pkg::ST_IDLE, ua: 8'hFF, blk: lbac_pkg::BLK_RST, res: '0,
                   default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reg_rdata = s_ff.rdata;
   assign res_vld   = s_ff.res_vld;
   assign res       = s_ff.res;
   assign in_rdy    = s_ff.in_rdy;
   assign out_vld   = s_ff.out_vld;
   assign out_byte  = s_ff.out_byte;
   assign out_ecc   = s_ff.out_ecc;
   assign out_half  = s_ff.out_half;
   assign out_last  = s_ff.out_last;
   assign xfer_done = s_ff.done;

   a_ua_reset_all: assert property (@(posedge core_clk) disable iff (!rst_b)
      bus_rst |=> s_ff.ua == 8'hFF && s_ff.st == lbac_pkg::ST_IDLE)
      else $error("attention flags not all set after bus reset");
   a_ua_mode_others: assert property (@(posedge core_clk) disable iff (!rst_b)
      mode_chg |=> &(s_ff.ua | (8'h01 << $past(mode_chg_id))))
      else $error("mode change left another host without attention");
   a_ua_check_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && ua_hit && !exempt && !bus_rst && !ready_rise && !mode_chg |=>
      res_vld && res.kind == lbac_pkg::RK_CHECK && res.skey == lbac_pkg::SK_UNIT_ATTN
      && !s_ff.ua[$past(cmd_id)])
      else $error("flagged host did not get unit attention check");
   a_inquiry_keeps: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && ua_hit && cmd_cdb.op == lbac_pkg::OP_INQUIRY |=>
      s_ff.ua[$past(cmd_id)] && res.kind == lbac_pkg::RK_PASS)
      else $error("inquiry disturbed attention flag");
   a_len_mismatch: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && is_long && !(ua_hit && !exempt) && !rsv_bad && cmd_cdb.len != 16'h0000
      && !len_ok && !bus_rst |=> res.kind == lbac_pkg::RK_CHECK && res.ili && res.valid
      && res.asc == lbac_pkg::ASC_BAD_FIELD && s_ff.st == lbac_pkg::ST_IDLE && !in_rdy)
      else $error("length mismatch not reported");
   a_ili_long_only: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && !is_long |=> !res.ili)
      else $error("incorrect length bit from a short command");
   a_zero_seek: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && is_long && !ua_hit && !rsv_bad && cmd_cdb.len == 16'h0000 && !bus_rst |=>
      res.kind == lbac_pkg::RK_GOOD && res.seek && s_ff.st == lbac_pkg::ST_IDLE)
      else $error("zero length long command not a plain seek");
   a_last_count: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_vld && out_last |-> s_ff.idx == s_ff.len && out_ecc)
      else $error("image ended at wrong byte count");
endmodule : lbac_top

// ==== tb/lbac_host_model.sv ====
module lbac_host_model (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        slow,
   input  wire logic        clr,
   output      logic        in_vld,
   output      logic [7:0]  in_byte,
   input  wire logic        in_rdy,
   input  wire logic        out_vld,
   input  wire logic [7:0]  out_byte,
   input  wire logic        out_ecc,
   input  wire logic        out_half,
   output      logic        out_rdy,
   output      logic [15:0] n_out,
   output      logic [15:0] n_ecc,
   output      logic [15:0] n_half,
   output      logic [15:0] n_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] seq_ff;
   logic       vld_ff;
   // An idle byte line shows the inverse so a stale value is never mistaken for data.
   assign in_byte = vld_ff ? seq_ff : ~seq_ff;
   assign in_vld  = vld_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         {vld_ff, seq_ff, out_rdy, n_out, n_ecc, n_half, n_bad} <= '0;
      end else if (clr) begin
         {vld_ff, seq_ff, n_out, n_ecc, n_half, n_bad} <= '0;
      end else begin
         // Each image byte is offered and held until taken, in image order.
         vld_ff <= 1'b1;
         if (vld_ff && in_rdy) begin
            seq_ff <= seq_ff + 8'h01;
         end
         // A slow host stalls every other cycle to exercise the hold of the outputs.
         out_rdy <= !slow || !out_rdy;
         if (out_vld && out_rdy) begin
            n_out  <= n_out + 16'h0001;
            n_ecc  <= n_ecc + {15'h0000, out_ecc};
            n_half <= n_half + {15'h0000, out_half};
            n_bad  <= n_bad + {15'h0000, out_byte !== n_out[7:0]};
         end
      end
   end
endmodule : lbac_host_model

// ==== tb/lbac_top_tb.sv ====
module lbac_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                core_clk, rst_b, reg_wr, reg_rd, cmd_vld, res_vld;
   logic                ready_rise, bus_rst, mode_chg, in_vld, in_rdy, out_vld;
   logic                out_ecc, out_half, out_last, out_rdy, xfer_done, slow, clr;
   logic [7:0]          reg_addr, in_byte, out_byte;
   logic [31:0]         reg_wdata, reg_rdata;
   logic [2:0]          cmd_id, mode_chg_id;
   logic [15:0]         mode_chg_size, n_out, n_ecc, n_half, n_bad;
   lbac_pkg::lbac_cdb_t cmd_cdb;
   lbac_pkg::lbac_res_t res;
   int                  miscompares, tests_run, cyc;
   lbac_top lbac_top_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cmd_vld, .cmd_id, .cmd_cdb, .res_vld, .res, .ready_rise, .bus_rst,
      .mode_chg, .mode_chg_id, .mode_chg_size, .in_vld, .in_byte, .in_rdy, .out_vld,
      .out_byte, .out_ecc, .out_half, .out_last, .out_rdy, .xfer_done);
   lbac_host_model lbac_host_model_inst (.core_clk, .rst_b, .slow, .clr, .in_vld, .in_byte,
      .in_rdy, .out_vld, .out_byte, .out_ecc, .out_half, .out_rdy, .n_out, .n_ecc,
      .n_half, .n_bad);
   task results;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic cmd(input logic [2:0] id, input logic [7:0] op, input logic [15:0] len,
                      input logic [7:0] b1, input lbac_pkg::lbac_kind_t k);
      @(posedge core_clk);
      cmd_vld <= 1'b1;
      cmd_id  <= id;
      cmd_cdb <= '{op, b1, 32'h0000_1234, 8'h00, len, 8'h00};
      @(posedge core_clk);
      cmd_vld <= 1'b0;
      #1 chk("res_vld", 32'h1, res_vld);
      chk("kind", k, res.kind);
      chk("lba", 32'h0000_1234, res.lba);
   endtask : cmd
   task automatic sense(input logic [3:0] sk, input logic il, input logic [31:0] inf);
      chk("skey", sk, res.skey);
      chk("ili", il, res.ili);
      if (il) chk("info", inf, res.info);
      if (il) chk("asc", lbac_pkg::ASC_BAD_FIELD, res.asc);
      if (il) chk("valid", 32'h1, res.valid);
      chk("in_rdy", 32'h0, in_rdy);
   endtask : sense
   task automatic clear_all(input logic [7:0] m);
      for (int i = 0; i < 8; i++) begin
         cmd(3'(i), 8'h00, 16'h0000, 8'h00, m[i] ? lbac_pkg::RK_CHECK : lbac_pkg::RK_PASS);
      end
      rd(lbac_pkg::REG_UA, 32'h0);
   endtask : clear_all
   task automatic xfer(input logic [7:0] op, input logic [15:0] n, e, h);
      int sl = 0;
      int nl = 0;
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      cmd(3'h0, op, n, 8'h00, lbac_pkg::RK_XFER);
      chk("seek", 32'h1, res.seek);
      repeat (5000) begin
         @(posedge core_clk);
         #1;
         // The final marker may only appear on the byte after all others were taken.
         if (out_vld === 1'b1 && out_last === 1'b1) begin
            sl = 1;
            if (n_out !== 16'(n - 16'h0001)) nl++;
         end
         if (xfer_done === 1'b1) break;
      end
      chk("n_out", n, n_out);
      chk("n_ecc", e, n_ecc);
      chk("n_half", h, n_half);
      chk("n_bad", 32'h0, n_bad);
      chk("out_last", 32'h1, sl);
      chk("early_last", 32'h0, nl);
   endtask : xfer
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // The ceiling leaves generous room over the longest slow transfers.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      {rst_b, reg_wr, reg_rd, cmd_vld, ready_rise, bus_rst, mode_chg, slow, clr} = '0;
      {reg_addr, reg_wdata, cmd_id, mode_chg_id, mode_chg_size, cmd_cdb} = '0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(lbac_pkg::REG_UA, 32'hFF);
      rd(lbac_pkg::REG_BLK, 32'h200);
      rd(8'h08, 32'h0);
      cmd(3'h0, lbac_pkg::OP_INQUIRY, 16'h0000, 8'h00, lbac_pkg::RK_PASS);
      rd(lbac_pkg::REG_UA, 32'hFF);
      cmd(3'h0, lbac_pkg::OP_REQ_SENSE, 16'h0000, 8'h00, lbac_pkg::RK_PASS);
      chk("ua_sense", 32'h1, res.ua_sense);
      rd(lbac_pkg::REG_UA, 32'hFE);
      cmd(3'h1, lbac_pkg::OP_PRIO_RSV, 16'h0000, 8'h00, lbac_pkg::RK_PASS);
      rd(lbac_pkg::REG_UA, 32'hFC);
      cmd(3'h2, lbac_pkg::OP_RD_LONG, 16'h0207, 8'h00, lbac_pkg::RK_CHECK);
      sense(lbac_pkg::SK_UNIT_ATTN, 1'b0, 32'h0);
      clear_all(8'hF8);
      @(posedge core_clk);
      ready_rise <= 1'b1;
      @(posedge core_clk);
      ready_rise <= 1'b0;
      clear_all(8'hFF);
      @(posedge core_clk);
      bus_rst <= 1'b1;
      @(posedge core_clk);
      bus_rst <= 1'b0;
      clear_all(8'hFF);
      @(posedge core_clk);
      {mode_chg, mode_chg_id, mode_chg_size} <= {1'b1, 3'h3, lbac_pkg::SZ_SHORT};
      @(posedge core_clk);
      mode_chg <= 1'b0;
      rd(lbac_pkg::REG_BLK, 32'h100);
      clear_all(8'hF7);
      cmd(3'h0, lbac_pkg::OP_RD_LONG, 16'h0106, 8'h00, lbac_pkg::RK_CHECK);
      sense(lbac_pkg::SK_ILLEGAL, 1'b1, 32'hFFFF_FFFF);
      xfer(lbac_pkg::OP_RD_LONG, 16'h0107, 16'h0007, 16'h0000);
      wr(lbac_pkg::REG_BLK, 32'h3E8);
      rd(lbac_pkg::REG_BLK, 32'h3E8);
      // A size write raises no attention, so a ready event sets every flag before the clear below.
      @(posedge core_clk);
      ready_rise <= 1'b1;
      @(posedge core_clk);
      ready_rise <= 1'b0;
      clear_all(8'hFF);
      slow <= 1'b1;
      xfer(lbac_pkg::OP_RD_LONG, 16'h03F6, 16'h000E, 16'h01FB);
      xfer(lbac_pkg::OP_WR_LONG, 16'h03F6, 16'h000E, 16'h01FB);
      chk("wr", 32'h1, res.wr);
      cmd(3'h0, lbac_pkg::OP_WR_LONG, 16'h03E8, 8'h00, lbac_pkg::RK_CHECK);
      sense(lbac_pkg::SK_ILLEGAL, 1'b1, 32'hFFFF_FFF2);
      cmd(3'h0, lbac_pkg::OP_RD_LONG, 16'h0000, 8'h00, lbac_pkg::RK_GOOD);
      chk("seek", 32'h1, res.seek);
      cmd(3'h0, lbac_pkg::OP_WR_LONG, 16'h0000, 8'h00, lbac_pkg::RK_GOOD);
      cmd(3'h0, lbac_pkg::OP_WR_LONG, 16'h03F6, 8'h01, lbac_pkg::RK_CHECK);
      sense(lbac_pkg::SK_ILLEGAL, 1'b0, 32'h0);
      // A bus reset in mid-transfer must drop the stream and leave the block idle.
      cmd(3'h0, lbac_pkg::OP_RD_LONG, 16'h03F6, 8'h00, lbac_pkg::RK_XFER);
      @(posedge core_clk);
      bus_rst <= 1'b1;
      @(posedge core_clk);
      bus_rst <= 1'b0;
      #1 chk("abort_in_rdy", 32'h0, in_rdy);
      chk("abort_out_vld", 32'h0, out_vld);
      rd(lbac_pkg::REG_UA, 32'hFF);
      cmd(3'h0, lbac_pkg::OP_INQUIRY, 16'h0000, 8'h00, lbac_pkg::RK_PASS);
      results();
   end
endmodule : lbac_top_tb
